/* File: hdl/mmx_regs.vh */
// Register offsets, field positions, reset values and opcodes of the MAC unit
`ifndef MMX_REGS_VH
`define MMX_REGS_VH

// Byte offsets of the 32-bit registers on the slave port
`define MMX_OFF_CTRL      8'h00
`define MMX_OFF_OP1       8'h04
`define MMX_OFF_OP2       8'h08
`define MMX_OFF_INSTR     8'h0c
`define MMX_OFF_SUM_LO    8'h10
`define MMX_OFF_SUM_HI    8'h14
`define MMX_OFF_MAC_FLAGS 8'h18
`define MMX_OFF_CPU_FLAGS 8'h1c
`define MMX_OFF_MEM_ADDR  8'h20
`define MMX_OFF_MEM_DATA  8'h24

// Control word fields
`define MMX_CTRL_SAT  0
`define MMX_CTRL_FRAC 1

// MAC flag fields
`define MMX_FL_SIGN  0
`define MMX_FL_ZERO  1
`define MMX_FL_CARRY 2
`define MMX_FL_STICK 3
`define MMX_FL_EXT   4
`define MMX_FL_CLIP  5
`define MMX_FL_RANGE 6

// Processor flag fields and bad-instruction bit
`define MMX_CPU_NEG  0
`define MMX_CPU_ZERO 1
`define MMX_CPU_END  2
`define MMX_CPU_BAD  8

// Reset values
`define MMX_CTRL_RST  2'h0
`define MMX_SUM_RST   40'h00_0000_0000
`define MMX_FLAGS_RST 7'h00
`define MMX_WORD_RST  16'h0000
`define MMX_INSTR_RST 32'h0000_0000

// First byte: operand addressing
`define MMX_AM_RR   8'ha3
`define MMX_AM_RI   8'h83
`define MMX_AM_PI   8'h93
`define MMX_AM_COPY 8'hd3

// Third byte: operation
`define MMX_SUB_MAC  8'h90
`define MMX_SUB_MACR 8'h91
`define MMX_SUB_MSUB 8'ha0
`define MMX_SUB_MAX  8'h3a
`define MMX_SUB_MIN  8'h7a
`define MMX_SUB_MULR 8'hc1
`define MMX_SUB_COPY 8'h00

// Arithmetic constants
`define MMX_RND      40'h00_0000_8000
`define MMX_MAX40    40'h7f_ffff_ffff
`define MMX_MIN40    40'h80_0000_0000
`define MMX_MOSTNEG  16'h8000
`define MMX_MULR_SAT 40'h00_7fff_0000

`endif

/* File: hdl/mmx_mac_unit.v */
// Mixed-sign MAC, running max/min, word copy and rounding multiply datapath
//
// Contract
// - Mixed accumulate: unsigned times signed, add
// - Mixed subtract: same product, subtract from sum
// - Rounding accumulate adds 8000h, clears low word
// - Range-exceeded flag marks 40-bit overflow, else cleared
// - Sticky range flag sets on overflow, else holds
// - Clipped flag set on saturation, else holds
// - Extension flag follows use of top byte
// - Carry flag follows carry or borrow
// - Zero flag follows 40-bit result zero
// - Sign flag copies result bit 39
// - Running max loads concatenated operand if larger
// - Running min loads concatenated operand if smaller
// - Max/min: clipped on change, range/carry cleared
// - Max/min ignore saturation enable
// - Word copy moves memory word anywhere
// - Copy keeps MAC flags, sets zero/negative
// - Copy sets end flag on most negative word
// - Rounding multiply: optional shift, round, clear low
// - Rounding multiply clipped flag on 8000h squared with shift and saturation on
// - Rounding multiply extension flag on 8000h squared with shift on, saturation off
// - Four-byte instruction: addressing byte, operation byte
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`include "mmx_regs.vh"

module mmx_mac_unit #(
	parameter MEM_AW = 4
) (
	input  wire        clk,
	input  wire        arst_n,
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	output reg         cpu_end_flag,
	output reg         cpu_zero_flag,
	output reg         cpu_neg_flag
);

	// Depth of the word memory that the copy works on
	localparam MEM_WORDS = 1 << MEM_AW;
	// One-hot bus states: every access sees exactly one wait cycle.
	// Idle samples the request; the answer state completes it and the
	// slave falls back to idle, so back-to-back accesses each take two
	// cycles and no request is ever answered twice.
	localparam [1:0] ST_REQ = 2'b01;
	localparam [1:0] ST_ACK = 2'b10;

	////////////////////////////////////////////////////////////////////////
	// Byte-lane merge of a bus write into a register
	function [31:0] mmx_merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  be;
		integer i;
		begin
			mmx_merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i]) begin
					mmx_merge[i*8 +: 8] = nw[i*8 +: 8];
				end
			end
		end
	endfunction

	// Result uses the top byte when bits 39..31 are not all equal
	function mmx_ext;
		input [39:0] v;
		begin
			mmx_ext = ~((&v[39:31]) | ~(|v[39:31]));
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State
	reg [1:0]        st_q;
	reg [1:0]        ctrl_q;
	reg [15:0]       op1_q;
	reg [15:0]       op2_q;
	reg [31:0]       instr_q;
	reg [39:0]       sum_q;
	reg [6:0]        fl_q;
	reg              bad_q;
	reg [MEM_AW-1:0] maddr_q;
	// Memory is not reset: software writes a word before copying it
	reg [15:0]       mem [0:MEM_WORDS-1];

	reg [1:0]        st_d;
	reg [1:0]        ctrl_d;
	reg [15:0]       op1_d;
	reg [15:0]       op2_d;
	reg [31:0]       instr_d;
	reg [39:0]       sum_d;
	reg [6:0]        fl_d;
	reg              bad_d;
	reg [MEM_AW-1:0] maddr_d;
	reg              cend_d;
	reg              czero_d;
	reg              cneg_d;
	reg              mem_we;
	reg [MEM_AW-1:0] mem_wa;
	reg [15:0]       mem_wd;
	reg [31:0]       rdata_d;

	wire bus_req = avs_read | avs_write;
	wire bus_fire = st_q == ST_ACK;
	wire wr_fire = bus_fire & avs_write;
	wire [31:0] wmerge;
	assign wmerge = mmx_merge(32'h0000_0000, avs_writedata, avs_byteenable);

	// Register images after a byte-lane write, cut to register width later
	wire [31:0] ctrl_m = mmx_merge({30'h0, ctrl_q}, avs_writedata,
		avs_byteenable);
	wire [31:0] op1_m = mmx_merge({16'h0, op1_q}, avs_writedata,
		avs_byteenable);
	wire [31:0] op2_m = mmx_merge({16'h0, op2_q}, avs_writedata,
		avs_byteenable);

	////////////////////////////////////////////////////////////////////////
	// Products and sums
	wire sat_on = ctrl_q[`MMX_CTRL_SAT];
	wire frac_on = ctrl_q[`MMX_CTRL_FRAC];
	wire [7:0] am_byte = avs_writedata[7:0];
	wire [7:0] sub_byte = avs_writedata[23:16];

	// Mixed product: op1 unsigned, op2 signed. A zero guard bit keeps op1
	// positive in a signed multiply; the product always fits 32 bits.
	wire signed [16:0] mix_a = {1'b0, op1_q};
	wire signed [16:0] mix_b = {op2_q[15], op2_q};
	wire signed [33:0] mix_p = mix_a * mix_b;
	wire [39:0] mix40 = {{8{mix_p[31]}}, mix_p[31:0]};

	// Signed product for the rounding multiply. Only 8000h squared can
	// reach bit 31 after the shift, which is why that pair is special.
	wire signed [15:0] ss_a = op1_q;
	wire signed [15:0] ss_b = op2_q;
	wire signed [31:0] ss_p = ss_a * ss_b;
	wire [39:0] ss40 = {{8{ss_p[31]}}, ss_p};
	wire [39:0] ss_sh = frac_on ? {ss40[38:0], 1'b0} : ss40;
	wire [39:0] mulr_raw = ss_sh + `MMX_RND;
	wire both_neg = (op1_q == `MMX_MOSTNEG) & (op2_q == `MMX_MOSTNEG);

	// Accumulate with optional rounding constant, signed and unsigned views
	// One guard bit on top: bits 40 and 39 differ exactly when the true
	// sum leaves the 40-bit range, which is what overflow and clipping
	// need. The unsigned view gives the carry out of bit 39 instead.
	wire        is_rnd = sub_byte == `MMX_SUB_MACR;
	wire [39:0] rnd_add = is_rnd ? `MMX_RND : `MMX_SUM_RST;
	wire [40:0] add_s = {sum_q[39], sum_q} + {mix40[39], mix40}
		+ {1'b0, rnd_add};
	wire [40:0] add_u = {1'b0, sum_q} + {1'b0, mix40} + {1'b0, rnd_add};
	wire [40:0] sub_s = {sum_q[39], sum_q} - {mix40[39], mix40};
	// Borrow is the unsigned view of the subtraction, not its sign
	wire        borrow = sum_q < mix40;

	// Concatenated compare operand
	wire signed [39:0] cmp_op = {{8{op2_q[15]}}, op2_q, op1_q};
	wire signed [39:0] sum_s = sum_q;

	////////////////////////////////////////////////////////////////////////
	// Register update and instruction execution. Everything happens at the
	// accept edge of a write; an instruction completes in that one cycle,
	// so its result is visible to the very next read.
	reg [40:0] wide;
	reg [39:0] res;
	reg        ovf;
	reg        valid;
	reg [15:0] src_w;
	always @* begin
		wide = 41'h0;
		res = sum_q;
		ovf = 1'b0;
		valid = 1'b0;
		src_w = mem[op2_q[MEM_AW-1:0]];
		st_d = st_q;
		ctrl_d = ctrl_q;
		op1_d = op1_q;
		op2_d = op2_q;
		instr_d = instr_q;
		sum_d = sum_q;
		fl_d = fl_q;
		bad_d = bad_q;
		maddr_d = maddr_q;
		cend_d = cpu_end_flag;
		czero_d = cpu_zero_flag;
		cneg_d = cpu_neg_flag;
		mem_we = 1'b0;
		mem_wa = maddr_q;
		mem_wd = avs_writedata[15:0];
		// Bus handshake: one wait cycle, then the access completes
		case (st_q)
			ST_REQ: st_d = bus_req ? ST_ACK : ST_REQ;
			ST_ACK: st_d = ST_REQ;
			default: st_d = ST_REQ;
		endcase
		if (wr_fire) begin
			case (avs_address & 8'hfc)
				`MMX_OFF_CTRL: ctrl_d = ctrl_m[1:0];
				`MMX_OFF_OP1: op1_d = op1_m[15:0];
				`MMX_OFF_OP2: op2_d = op2_m[15:0];
				`MMX_OFF_SUM_LO: sum_d[31:0] = mmx_merge(sum_q[31:0],
					avs_writedata, avs_byteenable);
				`MMX_OFF_SUM_HI: begin
					if (avs_byteenable[0]) begin
						sum_d[39:32] = avs_writedata[7:0];
					end
				end
				`MMX_OFF_MAC_FLAGS: begin
					if (avs_byteenable[0]) begin
						fl_d = avs_writedata[6:0];
					end
				end
				`MMX_OFF_MEM_ADDR: maddr_d = wmerge[MEM_AW-1:0];
				`MMX_OFF_MEM_DATA: mem_we = 1'b1;
				`MMX_OFF_INSTR: begin
					instr_d = avs_writedata;
					// Addressing byte, then operation byte
					valid = (am_byte == `MMX_AM_RR)
						| (am_byte == `MMX_AM_RI)
						| (am_byte == `MMX_AM_PI);
					if (am_byte == `MMX_AM_COPY) begin
						valid = sub_byte == `MMX_SUB_COPY;
						if (valid) begin
							// Copy touches the target word and processor flags only
							mem_we = 1'b1;
							mem_wa = op1_q[MEM_AW-1:0];
							mem_wd = src_w;
							czero_d = src_w == `MMX_WORD_RST;
							cneg_d = src_w[15];
							cend_d = src_w == `MMX_MOSTNEG;
						end
					end else if (valid) begin
						case (sub_byte)
							`MMX_SUB_MAC, `MMX_SUB_MACR, `MMX_SUB_MSUB:
							begin
								wide = (sub_byte == `MMX_SUB_MSUB) ?
									sub_s : add_s;
								ovf = wide[40] ^ wide[39];
								res = wide[39:0];
								if (ovf & sat_on) begin
									res = wide[40] ? `MMX_MIN40
										: `MMX_MAX40;
									fl_d[`MMX_FL_CLIP] = 1'b1;
								end
								if (is_rnd) begin
									res[15:0] = 16'h0000;
								end
								fl_d[`MMX_FL_RANGE] = ovf;
								if (ovf) begin
									fl_d[`MMX_FL_STICK] = 1'b1;
								end
								fl_d[`MMX_FL_CARRY] =
									(sub_byte == `MMX_SUB_MSUB) ?
									borrow : add_u[40];
							end
							`MMX_SUB_MAX, `MMX_SUB_MIN: begin
								// Saturation enable plays no part
								if (sub_byte == `MMX_SUB_MAX) begin
									if (sum_s < cmp_op) begin
										res = cmp_op;
									end
								end else if (sum_s > cmp_op) begin
									res = cmp_op;
								end
								if (res != sum_q) begin
									fl_d[`MMX_FL_CLIP] = 1'b1;
								end
								fl_d[`MMX_FL_RANGE] = 1'b0;
								fl_d[`MMX_FL_CARRY] = 1'b0;
							end
							`MMX_SUB_MULR: begin
								res = {mulr_raw[39:16], 16'h0000};
								if (frac_on & sat_on & both_neg) begin
									res = `MMX_MULR_SAT;
									fl_d[`MMX_FL_CLIP] = 1'b1;
								end
								fl_d[`MMX_FL_RANGE] = 1'b0;
								fl_d[`MMX_FL_CARRY] = 1'b0;
							end
							default: valid = 1'b0;
						endcase
						if (valid) begin
							sum_d = res;
							fl_d[`MMX_FL_ZERO] = res == `MMX_SUM_RST;
							fl_d[`MMX_FL_SIGN] = res[39];
							fl_d[`MMX_FL_EXT] = mmx_ext(res);
							if (sub_byte == `MMX_SUB_MULR) begin
								fl_d[`MMX_FL_EXT] = frac_on & ~sat_on
									& both_neg;
							end
						end
					end
					// Unknown encodings leave the datapath alone
					// and mark the word bad until a good one
					bad_d = ~valid;
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, captured at the wait cycle and held for the ack edge.
	// Sampling one cycle early lets the read data leave a flip-flop and
	// stand for the whole answer cycle; nothing can change a register
	// between the two edges, since the bus carries one access at a time.
	always @* begin
		rdata_d = avs_readdata;
		if (st_q == ST_REQ && avs_read) begin
			case (avs_address & 8'hfc)
				`MMX_OFF_CTRL: rdata_d = {30'h0, ctrl_q};
				`MMX_OFF_OP1: rdata_d = {16'h0, op1_q};
				`MMX_OFF_OP2: rdata_d = {16'h0, op2_q};
				`MMX_OFF_INSTR: rdata_d = instr_q;
				`MMX_OFF_SUM_LO: rdata_d = sum_q[31:0];
				`MMX_OFF_SUM_HI: rdata_d = {24'h0, sum_q[39:32]};
				`MMX_OFF_MAC_FLAGS: rdata_d = {25'h0, fl_q};
				`MMX_OFF_CPU_FLAGS: rdata_d = {23'h0, bad_q, 5'h0,
					cpu_end_flag, cpu_zero_flag, cpu_neg_flag};
				`MMX_OFF_MEM_ADDR: rdata_d = {{(32-MEM_AW){1'b0}}, maddr_q};
				`MMX_OFF_MEM_DATA: rdata_d = {16'h0, mem[maddr_q]};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control and datapath flip-flops; waitrequest and read data come
	// straight from here so the bus sees no combinational path
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= ST_REQ;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
			ctrl_q <= `MMX_CTRL_RST;
			op1_q <= `MMX_WORD_RST;
			op2_q <= `MMX_WORD_RST;
			instr_q <= `MMX_INSTR_RST;
			sum_q <= `MMX_SUM_RST;
			fl_q <= `MMX_FLAGS_RST;
			bad_q <= 1'b0;
			maddr_q <= {MEM_AW{1'b0}};
			cpu_end_flag <= 1'b0;
			cpu_zero_flag <= 1'b0;
			cpu_neg_flag <= 1'b0;
		end else begin
			st_q <= st_d;
			avs_waitrequest <= st_d != ST_ACK;
			avs_readdata <= rdata_d;
			ctrl_q <= ctrl_d;
			op1_q <= op1_d;
			op2_q <= op2_d;
			instr_q <= instr_d;
			sum_q <= sum_d;
			fl_q <= fl_d;
			bad_q <= bad_d;
			maddr_q <= maddr_d;
			cpu_end_flag <= cend_d;
			cpu_zero_flag <= czero_d;
			cpu_neg_flag <= cneg_d;
		end
	end

	// Word memory, written by the bus or by the copy. The two never meet
	// in one cycle, as both come from a single accepted bus write. No
	// reset here, so the array can map onto plain memory cells.
	always @(posedge clk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

endmodule

/* File: bench/mmx_host_model.sv */
// Host model: Avalon master that issues register accesses to the MAC unit
module mmx_host_model (
	input  wire logic        clk,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	output logic      [7:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata,
	output logic      [3:0]  avs_byteenable
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus at time zero
	initial begin
		avs_address    = 8'h00;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h0;
		avs_byteenable = 4'hf;
	end

	// One access: held until waitrequest is sampled low, then released
	task automatic acc(input logic r, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_read      <= r;
		avs_write     <= !r;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read      <= 1'b0;
		avs_write     <= 1'b0;
		avs_writedata <= ~d;
	endtask
endmodule

/* File: bench/mmx_mac_unit_monitor.sv */
// Checker on the MAC unit ports: handshake, readback widths, copy flags
module mmx_monitor (
	input wire        clk,
	input wire        arst_n,
	input wire [7:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	input wire        cpu_end_flag,
	input wire        cpu_zero_flag,
	input wire        cpu_neg_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// Accepted read and word index of the address
	wire       rd_ok = avs_read && !avs_waitrequest;
	wire [5:0] wa    = avs_address[7:2];
	wire [2:0] cpu   = {cpu_end_flag, cpu_zero_flag, cpu_neg_flag};

	////////////////////////////////////////////////////////////////////////
	a_wait_answer: assert property ((avs_read || avs_write) &&
		avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
	a_wait_pulse: assert property (!avs_waitrequest |=>
		avs_waitrequest) else $error("wait low too long");
	a_idle_wait: assert property (!(avs_read || avs_write) |=>
		avs_waitrequest) else $error("answer without request");
	a_flags_hold: assert property (!$stable(cpu) |->
		$past(avs_write && !avs_waitrequest && wa == 6'h03))
		else $error("cpu flags moved without instruction");
	a_end_neg: assert property (cpu_end_flag |-> cpu_neg_flag &&
		!cpu_zero_flag) else $error("end flag without negative");
	a_zero_pos: assert property (cpu_zero_flag |->
		!cpu_neg_flag) else $error("zero and negative together");
	a_cpu_read: assert property (rd_ok && wa == 6'h07 |->
		avs_readdata[2:0] == cpu) else $error("cpu flag readback");
	a_sum_top: assert property (rd_ok && wa == 6'h05 |->
		avs_readdata[31:8] == 24'h0) else $error("sum top not 8 bits");
	a_flag_width: assert property (rd_ok && wa == 6'h06 |->
		avs_readdata[31:7] == 25'h0) else $error("mac flags too wide");
	a_data_hold: assert property (!$stable(avs_readdata) |->
		$past(avs_read)) else $error("read data moved without read");
	a_unmapped_zero: assert property (rd_ok && wa >= 6'h0a |->
		avs_readdata == 32'h0) else $error("unmapped read not zero");

	// Main scenarios
	c_cpu_read: cover property (rd_ok && wa == 6'h07);
	c_instr: cover property (avs_write && !avs_waitrequest && wa == 6'h03);
	c_end: cover property ($rose(cpu_end_flag));
endmodule

bind mmx_mac_unit mmx_monitor u_mon (
	.clk             (clk),
	.arst_n          (arst_n),
	.avs_address     (avs_address),
	.avs_read        (avs_read),
	.avs_write       (avs_write),
	.avs_readdata    (avs_readdata),
	.avs_waitrequest (avs_waitrequest),
	.cpu_end_flag    (cpu_end_flag),
	.cpu_zero_flag   (cpu_zero_flag),
	.cpu_neg_flag    (cpu_neg_flag)
);

/* File: bench/tb_top.sv */
// Testbench: runs MAC instructions over the register bus and checks results
`include "mmx_regs.vh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	wire  [7:0]  avs_address;
	wire         avs_read;
	wire         avs_write;
	wire  [31:0] avs_writedata;
	wire  [3:0]  avs_byteenable;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest;
	wire         cpu_end_flag;
	wire         cpu_zero_flag;
	wire         cpu_neg_flag;
	int          n_fail = 0;
	int          checked = 0;
	logic [31:0] q;
	logic [31:0] lo;

	// 10 MHz clock
	always #50 clk = ~clk;

	mmx_mac_unit u_dut (
		.clk             (clk),
		.arst_n          (arst_n),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_byteenable  (avs_byteenable),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.cpu_end_flag    (cpu_end_flag),
		.cpu_zero_flag   (cpu_zero_flag),
		.cpu_neg_flag    (cpu_neg_flag)
	);

	mmx_host_model u_host (
		.clk             (clk),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_byteenable  (avs_byteenable)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus helpers and comparison
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_host.acc(1'b0, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a);
		u_host.acc(1'b1, a, 32'h0, q);
	endtask

	task automatic chk(input logic [39:0] g, input logic [39:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask

	// Preset control, flags and sum, issue one instruction, read back
	task automatic run(input logic [1:0] c, input logic [6:0] f,
		input logic [39:0] s0, input logic [31:0] ab,
		input logic [15:0] oa, input logic [39:0] es,
		input logic [6:0] ef);
		wr(`MMX_OFF_CTRL, {30'h0, c});
		wr(`MMX_OFF_MAC_FLAGS, {25'h0, f});
		wr(`MMX_OFF_SUM_LO, s0[31:0]);
		wr(`MMX_OFF_SUM_HI, {24'h0, s0[39:32]});
		wr(`MMX_OFF_OP1, {16'h0, ab[15:0]});
		wr(`MMX_OFF_OP2, {16'h0, ab[31:16]});
		wr(`MMX_OFF_INSTR, {8'h0, oa[15:8], 8'h0, oa[7:0]});
		rd(`MMX_OFF_SUM_LO);
		lo = q;
		rd(`MMX_OFF_SUM_HI);
		chk({q[7:0], lo}, es);
		rd(`MMX_OFF_MAC_FLAGS);
		chk({33'h0, q[6:0]}, {33'h0, ef});
	endtask

	// Word copy from src into word 9, checking cpu and mac flags
	task automatic cp(input logic [3:0] src, input logic [15:0] d,
		input logic [2:0] ef);
		wr(`MMX_OFF_MAC_FLAGS, 32'h55);
		wr(`MMX_OFF_OP1, 32'h9);
		wr(`MMX_OFF_OP2, {28'h0, src});
		wr(`MMX_OFF_INSTR, 32'h0000_00d3);
		rd(`MMX_OFF_CPU_FLAGS);
		chk({31'h0, q[8:0]}, {37'h0, ef});
		chk({37'h0, cpu_end_flag, cpu_zero_flag, cpu_neg_flag},
			{37'h0, ef});
		rd(`MMX_OFF_MAC_FLAGS);
		chk({8'h0, q}, 40'h55);
		wr(`MMX_OFF_MEM_ADDR, 32'h9);
		rd(`MMX_OFF_MEM_DATA);
		chk({8'h0, q}, {24'h0, d});
	endtask

	task automatic results;
		if (n_fail == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		results;
	end

	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		run(2'h0,7'h00,40'h0,32'hffffffff,16'h90a3,40'hffffff0001,7'h01);
		run(2'h0,7'h00,40'hffffff0001,32'hffffffff,16'ha083,40'h0,7'h02);
		run(2'h0,7'h00,40'h0,32'h40000002,16'h9193,40'h10000,7'h00);
		run(2'h0,7'h00,40'hffffffffff,32'h10001,16'h90a3,40'h0,7'h06);
		run(2'h0,7'h00,40'h0,32'h10001,16'ha0a3,40'hffffffffff,7'h05);
		run(2'h0,7'h00,40'h7fffffffff,32'h10001,16'h90a3,40'h8000000000,7'h59);
		run(2'h1,7'h00,40'h7fffffffff,32'h10001,16'h90a3,40'h7fffffffff,7'h78);
		run(2'h1,7'h00,40'h8000000000,32'h10001,16'ha0a3,40'h8000000000,7'h79);
		run(2'h0,7'h28,40'h0,32'h0,16'h90a3,40'h0,7'h2a);
		run(2'h1,7'h00,40'h0,32'h80000000,16'h3aa3,40'h0,7'h02);
		run(2'h1,7'h00,40'h0,32'h12345678,16'h3a83,40'h12345678,7'h20);
		run(2'h0,7'h00,40'h0,32'h80000000,16'h7a93,40'hff80000000,7'h21);
		run(2'h0,7'h4c,40'hff80000000,32'h10000,16'h7aa3,40'hff80000000,7'h09);
		run(2'h3,7'h00,40'h0,32'h80008000,16'hc1a3,40'h7fff0000,7'h20);
		run(2'h2,7'h20,40'h0,32'h80008000,16'hc183,40'h80000000,7'h30);
		run(2'h0,7'h64,40'h0,32'hc0000004,16'hc193,40'hffffff0000,7'h21);
		wr(`MMX_OFF_MEM_ADDR, 32'h3);
		wr(`MMX_OFF_MEM_DATA, 32'h8000);
		wr(`MMX_OFF_MEM_ADDR, 32'h5);
		wr(`MMX_OFF_MEM_DATA, 32'h0);
		cp(4'h3, 16'h8000, 3'h5);
		cp(4'h5, 16'h0, 3'h2);
		wr(`MMX_OFF_INSTR, 32'h0055_00a3);
		rd(`MMX_OFF_CPU_FLAGS);
		chk({39'h0, q[8]}, 40'h1);
		rd(8'h40);
		chk({8'h0, q}, 40'h0);
		results;
	end
endmodule
